// *** pm_clkgate_defs.vh ***
// Register map, field positions, reset values and widths of the
// clock gate, clock-ready interrupt and reset-cause block.
// Assumes byte addressing on a 32-bit APB bus, one word per register.
`ifndef PM_CLKGATE_DEFS_VH
`define PM_CLKGATE_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_BUS_C_CLOCK_GATES   6'h20
`define IDX_IRQ_ENABLE_CLEAR    6'h34
`define IDX_IRQ_ENABLE_SET      6'h35
`define IDX_IRQ_FLAG_STATUS     6'h36
`define IDX_LAST_RESET_SOURCE   6'h38
`define IDX_WRITE_LOCK          6'h3C

// Bus address width
`define ADDR_W                  8

// Gate register: reset value and writable bits
`define GATES_RESET             32'h0001_0000
`define GATES_WR_MASK           32'h000F_FFFF
`define GATE_TOP_BIT            10
`define GATE_COUNT              11

// Clock-ready bit position in enable and flag registers
`define CLOCKS_SETTLED_BIT      0

// Reset-cause field positions and reset value
`define CAUSE_POWER_ON_BIT      0
`define CAUSE_BROWNOUT_1V2_CAUSE_BIT         1
`define CAUSE_BROWNOUT_3V3_CAUSE_BIT         2
`define CAUSE_PIN_BIT           4
`define CAUSE_WATCHDOG_BIT      5
`define CAUSE_SW_SYSTEM_BIT     6
`define CAUSE_RESET             8'h01
`define CAUSE_USED_MASK         8'h77

// Write-lock register field
`define WRITE_LOCK_BIT          0

// Width of the packed divider selections watched for clock-ready
`define DIV_SEL_W               12

`endif

// *** clocks_settled_detect.v ***
// Raises a one-cycle pulse when the applied divider selections first
// match the requested ones. Both inputs come from logic on CORE_CLK.
`timescale 1ns/100ps

module clocks_settled_detect #(
	parameter SEL_W = 12
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// Requested and applied divider selections
	input  wire [SEL_W-1:0] target_sel,
	input  wire [SEL_W-1:0] applied_sel,
	// Settled event
	output reg              settled_pulse
);

	reg  match_ff;
	wire match;

	// Clocks run as selected when every field agrees
	assign match = (target_sel == applied_sel);

	// Registered pulse, one cycle after the match is first seen
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			match_ff      <= 1'b0;
			settled_pulse <= 1'b0;
		end else begin
			match_ff      <= match;
			settled_pulse <= match & ~match_ff;
		end
	end

endmodule // clocks_settled_detect

// *** reset_cause_capture.v ***
// Records which source caused the last system reset.
// Cause inputs are held levels from the reset controller, asynchronous
// to CORE_CLK; they are synchronised and sampled once after release.
`timescale 1ns/100ps

`include "pm_clkgate_defs.vh"

module reset_cause_capture (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Raw cause indications, bit positions as in the cause register
	input  wire [7:0] cause_raw,
	// Captured cause
	output reg  [7:0] cause_ff
);

	reg [7:0] sync1_ff;
	reg [7:0] sync2_ff;
	reg [1:0] wait_ff;
	reg       done_ff;

	// Two-stage synchroniser for the cause levels
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= 8'h00;
			sync2_ff <= 8'h00;
		end else begin
			sync1_ff <= cause_raw;
			sync2_ff <= sync1_ff;
		end
	end

	// Capture once, after the synchroniser has filled
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_ff <= `CAUSE_RESET;
			wait_ff  <= 2'b00;
			done_ff  <= 1'b0;
		end else if (!done_ff) begin
			if (wait_ff == 2'b10) begin
				done_ff <= 1'b1;
				// Nothing seen means a power-on start
				if ((sync2_ff & `CAUSE_USED_MASK) != 8'h00)
					cause_ff <= sync2_ff & `CAUSE_USED_MASK;
			end else begin
				wait_ff <= wait_ff + 2'b01;
			end
		end
	end

endmodule // reset_cause_capture

// *** clock_gate_irq_reset_cause.v ***
// Peripheral bus clock gates, clock-ready interrupt and reset cause,
// reached by software over a 32-bit APB slave.
// Assumes divider selections and cause levels come from the power
// manager around it; gate enables drive external clock gating cells.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps

`include "pm_clkgate_defs.vh"

// Operation
// - Gate bits 10..0 stop their peripheral bus clock at zero, pass at one.
// - Writing one to enable-clear drops the clock-ready enable; the clock-ready flag stays set.
// - Writing one to enable-set raises the clock-ready enable; zero does nothing.
// - Interrupt asserts while enable and clock-ready flag are both set.
// - Clock-ready flag sets when processor and bus clocks reach selected rates.
// - Writing one to flag bit 0 clears the clock-ready flag; zero does nothing.
// - Reset-cause bit 0 marks power-on; register reads 0x01 after power-on.
// - Reset-cause bit 6 marks a processor-issued system reset request.
// - Reset-cause bit 5 marks a watchdog timer reset.
// - Reset-cause bit 4 marks an external pin reset.
// - Reset-cause bit 2 marks a 3.3 V brown-out reset.
// - Reset-cause bit 1 marks a 1.2 V brown-out reset.
// - Gate register resets to 0x00010000, so covered gates start stopped.
module clock_gate_irq_reset_cause #(
	parameter SEL_W = `DIV_SEL_W
) (
	// Clock and reset
	input  wire               CORE_CLK,
	input  wire               RSTN,
	// APB slave
	input  wire [`ADDR_W-1:0] PADDR,
	input  wire               PSEL,
	input  wire               PENABLE,
	input  wire               PWRITE,
	input  wire [31:0]        PWDATA,
	output reg  [31:0]        PRDATA,
	output reg                PREADY,
	output reg                PSLVERR,
	// Divider selections, requested and applied
	input  wire [SEL_W-1:0]   TARGET_DIV_SEL,
	input  wire [SEL_W-1:0]   APPLIED_DIV_SEL,
	// Held reset-cause levels from the reset controller
	input  wire               SOFTWARE_SYSTEM_RESET_CAUSE,
	input  wire               WATCHDOG_RESET_CAUSE,
	input  wire               PIN_RESET_CAUSE,
	input  wire               BROWNOUT_3V3_CAUSE,
	input  wire               BROWNOUT_1V2_CAUSE,
	// Peripheral bus clock enables
	output reg  [`GATE_COUNT-1:0] BUS_C_GATE_EN,
	// Interrupt request
	output reg                IRQ
);

	// Register state
	reg  [31:0] gates_ff;
	reg  [31:0] nxt_gates;
	reg         irq_en_ff;
	reg         nxt_irq_en;
	reg         flag_ff;
	reg         nxt_flag;
	reg         lock_ff;
	reg         nxt_lock;

	// Bus response next values
	reg  [31:0] nxt_rdata;
	reg         nxt_ready;
	reg         nxt_slverr;

	// Decode and helpers
	wire        setup_phase;
	wire        wr_commit;
	wire [5:0]  word_idx;
	wire        aligned;
	reg         hit_gates;
	reg         hit_en_clr;
	reg         hit_en_set;
	reg         hit_flag;
	reg         hit_cause;
	reg         hit_lock;
	wire        mapped;
	wire        settled_pulse;
	wire [7:0]  cause_raw;
	wire [7:0]  cause_val;
	wire        wr_open;
	wire        wr_gates;
	wire        wr_en_clr;
	wire        wr_en_set;
	wire        wr_flag;
	wire        wr_lock;
	wire        bad_addr;
	wire        ro_write;
	reg         nxt_irq;
	wire [`GATE_COUNT-1:0] nxt_gate_en;
	genvar      g;

	// Transfer phases: answer is prepared in setup, completes in access
	assign setup_phase = PSEL & ~PENABLE;
	assign wr_commit   = PSEL & PENABLE & PREADY & PWRITE;

	// Word index from byte address
	assign word_idx = PADDR[`ADDR_W-1:2];
	assign aligned  = (PADDR[1:0] == 2'b00);

	// Address decode
	always @* begin
		hit_gates  = 1'b0;
		hit_en_clr = 1'b0;
		hit_en_set = 1'b0;
		hit_flag   = 1'b0;
		hit_cause  = 1'b0;
		hit_lock   = 1'b0;
		if (!aligned) begin
			hit_gates = 1'b0;
		end else if (word_idx == `IDX_BUS_C_CLOCK_GATES) begin
			hit_gates = 1'b1;
		end else if (word_idx == `IDX_IRQ_ENABLE_CLEAR) begin
			hit_en_clr = 1'b1;
		end else if (word_idx == `IDX_IRQ_ENABLE_SET) begin
			hit_en_set = 1'b1;
		end else if (word_idx == `IDX_IRQ_FLAG_STATUS) begin
			hit_flag = 1'b1;
		end else if (word_idx == `IDX_LAST_RESET_SOURCE) begin
			hit_cause = 1'b1;
		end else if (word_idx == `IDX_WRITE_LOCK) begin
			hit_lock = 1'b1;
		end
	end

	assign mapped = hit_gates | hit_en_clr | hit_en_set | hit_flag | hit_cause | hit_lock;

	// Write strobes per register; the lock only guards the protected ones
	assign wr_open   = wr_commit & ~lock_ff;
	assign wr_gates  = wr_open & hit_gates;
	assign wr_en_clr = wr_open & hit_en_clr;
	assign wr_en_set = wr_open & hit_en_set;
	assign wr_flag   = wr_commit & hit_flag;
	assign wr_lock   = wr_commit & hit_lock;

	// Error sources: nothing mapped there, or a write to the read-only cause
	assign bad_addr = ~mapped;
	assign ro_write = PWRITE & hit_cause;

	// Clock-ready detection on the divider selections
	clocks_settled_detect #(
		.SEL_W         (SEL_W)
	) u_settle (
		.clk           (CORE_CLK),
		.rst_n         (RSTN),
		.target_sel    (TARGET_DIV_SEL),
		.applied_sel   (APPLIED_DIV_SEL),
		.settled_pulse (settled_pulse)
	);

	// Pack cause levels into their register positions
	assign cause_raw = {1'b0,
	                    SOFTWARE_SYSTEM_RESET_CAUSE,
	                    WATCHDOG_RESET_CAUSE,
	                    PIN_RESET_CAUSE,
	                    1'b0,
	                    BROWNOUT_3V3_CAUSE,
	                    BROWNOUT_1V2_CAUSE,
	                    1'b0};

	// Cause capture, power-on value unless a source is seen at the single sample after release
	reset_cause_capture u_cause (
		.clk       (CORE_CLK),
		.rst_n     (RSTN),
		.cause_raw (cause_raw),
		.cause_ff  (cause_val)
	);

	// Gate register writes, blocked by the lock
	always @* begin
		nxt_gates = gates_ff;
		if (wr_gates)
			nxt_gates = (gates_ff & ~`GATES_WR_MASK) | (PWDATA & `GATES_WR_MASK);
	end

	// Clock-ready interrupt enable, set and clear pair
	always @* begin
		nxt_irq_en = irq_en_ff;
		if (wr_en_set && PWDATA[`CLOCKS_SETTLED_BIT])
			nxt_irq_en = 1'b1;
		else if (wr_en_clr && PWDATA[`CLOCKS_SETTLED_BIT])
			nxt_irq_en = 1'b0;
	end

	// Clock-ready flag: a settle event wins over a clear in the same cycle
	always @* begin
		nxt_flag = flag_ff;
		if (wr_flag && PWDATA[`CLOCKS_SETTLED_BIT])
			nxt_flag = 1'b0;
		if (settled_pulse)
			nxt_flag = 1'b1;
	end

	// Write lock register, always writable
	always @* begin
		nxt_lock = lock_ff;
		if (wr_lock)
			nxt_lock = PWDATA[`WRITE_LOCK_BIT];
	end

	// Read data mux; unused bits read zero
	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (hit_gates) begin
			nxt_rdata = gates_ff;
		end else if (hit_en_clr || hit_en_set) begin
			nxt_rdata[`CLOCKS_SETTLED_BIT] = irq_en_ff;
		end else if (hit_flag) begin
			nxt_rdata[`CLOCKS_SETTLED_BIT] = flag_ff;
		end else if (hit_cause) begin
			nxt_rdata[7:0] = cause_val & `CAUSE_USED_MASK;
		end else if (hit_lock) begin
			nxt_rdata[`WRITE_LOCK_BIT] = lock_ff;
		end
	end

	// Bus response: ready for one cycle, error on unmapped or bad write
	always @* begin
		nxt_ready  = 1'b0;
		nxt_slverr = 1'b0;
		if (setup_phase) begin
			nxt_ready  = 1'b1;
			nxt_slverr = bad_addr | ro_write;
		end
	end

	// Gate register; reset value leaves every covered clock stopped
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			gates_ff <= `GATES_RESET;
		end else begin
			gates_ff <= nxt_gates;
		end
	end

	// Clock-ready interrupt enable
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_en_ff <= 1'b0;
		end else begin
			irq_en_ff <= nxt_irq_en;
		end
	end

	// Clock-ready flag
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// Write lock, open after reset
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			lock_ff <= 1'b0;
		end else begin
			lock_ff <= nxt_lock;
		end
	end

	// Handshake outputs from flops
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= nxt_ready;
			PSLVERR <= nxt_slverr;
		end
	end

	// Read data held through the access phase, cleared when idle
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PRDATA <= 32'h0000_0000;
		end else if (setup_phase && !PWRITE) begin
			PRDATA <= nxt_rdata;
		end else if (!PSEL) begin
			PRDATA <= 32'h0000_0000;
		end
	end

	// Interrupt level from next enable and flag, so it moves with them
	always @* begin
		nxt_irq = nxt_irq_en & nxt_flag;
	end

	// One enable per gate bit; zero stops that peripheral's bus clock
	generate
		for (g = 0; g <= `GATE_TOP_BIT; g = g + 1) begin : g_gate
			assign nxt_gate_en[g] = nxt_gates[g];
		end
	endgenerate

	// Gate enables, registered from next state
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			BUS_C_GATE_EN <= {`GATE_COUNT{1'b0}};
		end else begin
			BUS_C_GATE_EN <= nxt_gate_en;
		end
	end

	// Interrupt request, registered from next state
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= nxt_irq;
		end
	end

endmodule // clock_gate_irq_reset_cause

// *** cg_properties.sv ***
// Port checker for the clock gate, clock-ready interrupt and reset cause block.
// Bound to the top module; mirrors lock and enable from observed bus writes.
`timescale 1ns/100ps
module cg_checker #(
	parameter SEL_W = 12
) (
	// Clock and reset
	input wire             CORE_CLK,
	input wire             RSTN,
	// Bus
	input wire [7:0]       PADDR,
	input wire             PSEL,
	input wire             PENABLE,
	input wire             PWRITE,
	input wire [31:0]      PWDATA,
	input wire [31:0]      PRDATA,
	input wire             PREADY,
	input wire             PSLVERR,
	// Dividers and outputs
	input wire [SEL_W-1:0] TARGET_DIV_SEL,
	input wire [SEL_W-1:0] APPLIED_DIV_SEL,
	input wire [10:0]      BUS_C_GATE_EN,
	input wire             IRQ
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	// Write commit strobe
	wire wr = PSEL & PENABLE & PREADY & PWRITE;
	reg  lock_ff;
	reg  en_ff;
	// Shadow of lock and clock-ready enable
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			lock_ff <= 1'b0;
			en_ff   <= 1'b0;
		end else if (wr) begin
			if (PADDR == 8'hF0) lock_ff <= PWDATA[0];
			if (PADDR == 8'hD4 && PWDATA[0] && !lock_ff) en_ff <= 1'b1;
			if (PADDR == 8'hD0 && PWDATA[0] && !lock_ff) en_ff <= 1'b0;
		end
	end
	property p_gate_wr; wr && PADDR == 8'h80 && !lock_ff |=> BUS_C_GATE_EN == $past(PWDATA[10:0]); endproperty
	a_gate_wr: assert property (p_gate_wr) else $error("gate bad");
	property p_gate_lock; wr && PADDR == 8'h80 && lock_ff |=> $stable(BUS_C_GATE_EN); endproperty
	a_gate_lock: assert property (p_gate_lock) else $error("lock bad");
	property p_en_clr; wr && PADDR == 8'hD0 && PWDATA[0] && !lock_ff |=> !IRQ; endproperty
	a_en_clr: assert property (p_en_clr) else $error("clear bad");
	property p_irq_en; IRQ |-> en_ff; endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq no enable");
	property p_irq_flag; PREADY && !PWRITE && PADDR == 8'hD8 && $past(IRQ) |-> PRDATA[0]; endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("irq no flag");
	property p_settle; $rose(TARGET_DIV_SEL == APPLIED_DIV_SEL) && en_ff |-> ##2 IRQ; endproperty
	a_settle: assert property (p_settle) else $error("settle bad");
	property p_rsv; PREADY && !PWRITE && PADDR[7:4] == 4'hD |-> PRDATA[31:1] == 31'h0000_0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bad");
	property p_ro; PREADY && PWRITE && PADDR == 8'hE0 |-> PSLVERR; endproperty
	a_ro: assert property (p_ro) else $error("cause write bad");
	// Main scenarios
	c_irq: cover property ($rose(IRQ));
	c_err: cover property (PREADY && PSLVERR);
	c_all: cover property (BUS_C_GATE_EN == 11'h7FF);
endmodule // cg_checker

// *** clock_gate_irq_reset_cause_tb_top.sv ***
// Self-checking bench for the clock gate, clock-ready interrupt and reset cause block.
// Drives the APB slave directly; checker bound below.
`timescale 1ns/100ps
module clock_gate_irq_reset_cause_tb_top;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0000_0000;
	reg  [11:0] tgt = 12'h001;
	reg  [11:0] app = 12'h000;
	reg  [4:0]  cause = 5'h00;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire [10:0] gate_en;
	wire        irq;
	reg  [31:0] rd;
	reg  [31:0] err;
	integer     bad_count = 0;
	integer     cmp_count = 0;
	integer     i;
	// Clock
	always #5 clk = ~clk;
	clock_gate_irq_reset_cause uut (.CORE_CLK(clk), .RSTN(rstn), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TARGET_DIV_SEL(tgt), .APPLIED_DIV_SEL(app), .SOFTWARE_SYSTEM_RESET_CAUSE(cause[0]),
		.WATCHDOG_RESET_CAUSE(cause[1]), .PIN_RESET_CAUSE(cause[2]), .BROWNOUT_3V3_CAUSE(cause[3]),
		.BROWNOUT_1V2_CAUSE(cause[4]), .BUS_C_GATE_EN(gate_en), .IRQ(irq));
	task print_verdict;
		begin
			$display("compares %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// One APB transfer; outputs settle by the falling edge
	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clk);
			psel   <= 1'b1;
			pwrite <= w;
			paddr  <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			n = 0;
			while (pready !== 1'b1 && n < 20) begin
				@(posedge clk);
				n = n + 1;
			end
			if (n == 20) begin
				bad_count = bad_count + 1;
				print_verdict;
			end
			rd = prdata;
			err = {31'h0000_0000, pslverr};
			psel    <= 1'b0;
			penable <= 1'b0;
			@(negedge clk);
		end
	endtask
	task rdchk(input [7:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0000_0000);
			chk(rd, exp);
		end
	endtask
	// Flag sets after dividers match
	task settle;
		integer n;
		begin
			@(posedge clk);
			app <= 12'h000;
			@(posedge clk);
			app <= tgt;
			rd = 32'h0000_0000;
			n = 0;
			while (rd !== 32'h0000_0001 && n < 10) begin
				apb(1'b0, 8'hD8, 32'h0000_0000);
				n = n + 1;
			end
			chk(rd, 32'h0000_0001);
			if (rd !== 32'h0000_0001) print_verdict;
		end
	endtask
	task t_reset;
		begin
			rdchk(8'hE0, 32'h0000_0001);
			rdchk(8'h80, 32'h0001_0000);
			chk({21'h0_0000, gate_en}, 32'h0000_0000);
			$display("test reset done");
		end
	endtask
	task t_gates;
		begin
			for (i = 0; i < 11; i = i + 1) begin
				apb(1'b1, 8'h80, 32'h0000_0001 << i);
				chk({21'h0_0000, gate_en}, 32'h0000_0001 << i);
			end
			apb(1'b1, 8'h80, 32'hFFFF_FFFF);
			chk({21'h0_0000, gate_en}, 32'h0000_07FF);
			rdchk(8'h80, 32'h000F_FFFF);
			$display("test gates done");
		end
	endtask
	task t_irq;
		begin
			apb(1'b1, 8'hD4, 32'h0000_0000);
			rdchk(8'hD4, 32'h0000_0000);
			apb(1'b1, 8'hD4, 32'h0000_00FF);
			rdchk(8'hD0, 32'h0000_0001);
			settle;
			chk({31'h0000_0000, irq}, 32'h0000_0001);
			apb(1'b1, 8'hD8, 32'h0000_0000);
			rdchk(8'hD8, 32'h0000_0001);
			apb(1'b1, 8'hD0, 32'h0000_0001);
			chk({31'h0000_0000, irq}, 32'h0000_0000);
			apb(1'b1, 8'hD4, 32'h0000_0001);
			chk({31'h0000_0000, irq}, 32'h0000_0001);
			apb(1'b1, 8'hD8, 32'h0000_0001);
			chk({31'h0000_0000, irq}, 32'h0000_0000);
			$display("test interrupt done");
		end
	endtask
	task t_lock;
		begin
			apb(1'b1, 8'h80, 32'h0000_0005);
			apb(1'b1, 8'hF0, 32'h0000_0001);
			apb(1'b1, 8'h80, 32'h0000_0000);
			chk(err, 32'h0000_0000);
			chk({21'h0_0000, gate_en}, 32'h0000_0005);
			apb(1'b1, 8'hD0, 32'h0000_0001);
			rdchk(8'hD4, 32'h0000_0001);
			settle;
			apb(1'b1, 8'hD8, 32'h0000_0001);
			rdchk(8'hD8, 32'h0000_0000);
			apb(1'b1, 8'hF0, 32'h0000_0000);
			apb(1'b1, 8'hE0, 32'h0000_00FF);
			chk(err, 32'h0000_0001);
			apb(1'b0, 8'h81, 32'h0000_0000);
			chk(err, 32'h0000_0001);
			$display("test lock and errors done");
		end
	endtask
	task t_cause;
		integer k;
		begin
			for (k = 0; k < 5; k = k + 1) begin
				@(posedge clk);
				cause <= 5'h01 << k;
				rstn  <= 1'b0;
				repeat (2) @(posedge clk);
				rstn <= 1'b1;
				repeat (6) @(posedge clk);
				chk({21'h0_0000, gate_en}, 32'h0000_0000);
				rdchk(8'hE0, k < 3 ? 32'h0000_0040 >> k : 32'h0000_0004 >> (k - 3));
				cause <= 5'h00;
			end
			$display("test cause done");
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_gates;
		t_irq;
		t_lock;
		t_cause;
		print_verdict;
	end
endmodule // clock_gate_irq_reset_cause_tb_top
bind clock_gate_irq_reset_cause cg_checker #(.SEL_W(SEL_W)) u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PADDR(PADDR),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .TARGET_DIV_SEL(TARGET_DIV_SEL), .APPLIED_DIV_SEL(APPLIED_DIV_SEL),
	.BUS_C_GATE_EN(BUS_C_GATE_EN), .IRQ(IRQ));
